//--- two_wire_unit.sv
// Added by the designer: the address map and register access over AHB-Lite.
`default_nettype none
// ****************
// two wire master and slave port
// ****************
module two_wire_unit (
   // ahb clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // clock line, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // data line, open drain
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // wake request to power control
   output logic wake_req
);
   typedef struct packed {
      // bus address phase capture
      logic wr_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
      // master configuration
      logic m_en;
      logic ack_act;
      logic [7:0] baud;
      // master state
      two_wire_pkg::mstate_t ms;
      logic [7:0] shreg;
      logic [2:0] bitn;
      logic [7:0] tick;
      logic is_read;
      logic rd_flag;
      logic wr_flag;
      logic arb_lost;
      logic bus_err;
      logic rx_ack;
      logic lost_now;
      // slave configuration and state
      logic s_en;
      logic s_match_dis;
      logic s_mask_mode;
      logic s_gc_en;
      logic [6:0] s_addr;
      logic [6:0] s_mask;
      logic [9:0] s_addr10;
      logic s_amatch;
      logic s_coll;
      logic s_held;
      logic [7:0] s_shreg;
      logic [3:0] s_cnt;
      logic s_active;
      logic s_hold_req;
      // line drive
      logic scl_low;
      logic sda_low;
      logic wake;
   } unit_t;
   unit_t r_reg, r_next;
   logic start_seen, stop_seen, bus_busy;
   logic scl_q;
   logic tick_done;
   logic addr_hit;
   // ****************
   // bus condition detector
   // ****************
   bus_watch u_watch (
      .hclk(hclk),
      .hresetn(hresetn),
      .scl(scl_in),
      .sda(sda_in),
      .start_seen(start_seen),
      .stop_seen(stop_seen),
      .bus_busy(bus_busy)
   );
   assign tick_done = r_reg.tick == r_reg.baud;
   // slave address compare on received address byte
   always_comb begin
      if (r_reg.s_match_dis) begin
         addr_hit = 1'b1;
      end else if (r_reg.s_gc_en && r_reg.s_shreg[7:1] == 7'h00) begin
         addr_hit = 1'b1;
      end else if (r_reg.s_shreg[7:3] == 5'b11110) begin
         addr_hit = r_reg.s_shreg[2:1] == r_reg.s_addr10[9:8];
      end else if (r_reg.s_mask_mode) begin
         addr_hit = ((r_reg.s_shreg[7:1] ^ r_reg.s_addr) & ~r_reg.s_mask) == 7'h00;
      end else begin
         addr_hit = r_reg.s_shreg[7:1] == r_reg.s_addr || r_reg.s_shreg[7:1] == r_reg.s_mask;
      end
   end
   assign scl_q = scl_in;
   // ****************
   // next state
   // ****************
   always_comb begin
      r_next = r_reg;
      r_next.wr_pend = 1'b0;
      r_next.wake = 1'b0;
      // address phase capture
      if (hsel && hready && htrans[1]) begin
         r_next.wr_pend = hwrite;
         r_next.addr = haddr[7:0];
         if (!hwrite) begin
            unique case (haddr[7:0])
               two_wire_pkg::mctrl_off: r_next.rdata = {31'h0, r_reg.m_en};
               two_wire_pkg::master_status_reg_off: r_next.rdata = {24'h0, r_reg.rd_flag, r_reg.wr_flag,
                  r_reg.ms == two_wire_pkg::m_held, r_reg.rx_ack, r_reg.arb_lost,
                  r_reg.bus_err, bus_busy, r_reg.ack_act};
               two_wire_pkg::mbaud_off: r_next.rdata = {24'h0, r_reg.baud};
               two_wire_pkg::mdata_off: r_next.rdata = {24'h0, r_reg.shreg};
               two_wire_pkg::sctrl_off: r_next.rdata = {28'h0, r_reg.s_gc_en,
                  r_reg.s_mask_mode, r_reg.s_match_dis, r_reg.s_en};
               two_wire_pkg::saddr_off: r_next.rdata = {22'h0, r_reg.s_addr10};
               two_wire_pkg::smask_off: r_next.rdata = {25'h0, r_reg.s_mask};
               two_wire_pkg::sstatus_off: r_next.rdata = {28'h0, r_reg.s_amatch,
                  r_reg.s_coll, r_reg.s_held, r_reg.s_active};
               two_wire_pkg::sdata_off: r_next.rdata = {24'h0, r_reg.s_shreg};
               default: r_next.rdata = 32'h0000_0000;
            endcase
            // data read triggers receive of next byte
            if (haddr[7:0] == two_wire_pkg::mdata_off && r_reg.ms == two_wire_pkg::m_held) begin
               r_next.rd_flag = 1'b0;
               r_next.wr_flag = 1'b0;
               r_next.is_read = 1'b1;
               r_next.bitn = 3'h7;
               r_next.tick = 8'h00;
               r_next.sda_low = !r_reg.ack_act;
               r_next.ms = two_wire_pkg::m_ack_low;
            end
         end
      end
      // data phase write
      if (r_reg.wr_pend) begin
         unique case (r_reg.addr)
            two_wire_pkg::mctrl_off: r_next.m_en = hwdata[0];
            two_wire_pkg::master_status_reg_off: begin
               r_next.ack_act = hwdata[two_wire_pkg::ms_ack_act_bit];
               if (hwdata[two_wire_pkg::ms_arb_bit]) r_next.arb_lost = 1'b0;
               if (hwdata[two_wire_pkg::ms_err_bit]) r_next.bus_err = 1'b0;
            end
            two_wire_pkg::mbaud_off: r_next.baud = hwdata[7:0];
            two_wire_pkg::mcmd_off: begin
               if (hwdata[1:0] == two_wire_pkg::cmd_start && r_reg.m_en && !bus_busy
                  && r_reg.ms == two_wire_pkg::m_idle) begin
                  r_next.ms = two_wire_pkg::m_start_a;
                  r_next.tick = 8'h00;
               end else if (hwdata[1:0] == two_wire_pkg::cmd_stop
                  && r_reg.ms == two_wire_pkg::m_held) begin
                  r_next.ms = two_wire_pkg::m_stop_a;
                  r_next.sda_low = 1'b1;
                  r_next.tick = 8'h00;
               end
            end
            two_wire_pkg::mdata_off: begin
               // shifting blocks the write
               if (r_reg.ms == two_wire_pkg::m_held) begin
                  r_next.shreg = hwdata[7:0];
                  r_next.rd_flag = 1'b0;
                  r_next.wr_flag = 1'b0;
                  r_next.is_read = 1'b0;
                  r_next.lost_now = 1'b0;
                  r_next.bitn = 3'h7;
                  r_next.tick = 8'h00;
                  // first bit goes out at once, scl is already low
                  r_next.sda_low = !hwdata[7];
                  r_next.ms = two_wire_pkg::m_bit_low;
               end
            end
            two_wire_pkg::sctrl_off: begin
               r_next.s_en = hwdata[0];
               r_next.s_match_dis = hwdata[1];
               r_next.s_mask_mode = hwdata[2];
               r_next.s_gc_en = hwdata[3];
            end
            two_wire_pkg::saddr_off: begin
               r_next.s_addr10 = hwdata[9:0];
               r_next.s_addr = hwdata[6:0];
            end
            two_wire_pkg::smask_off: r_next.s_mask = hwdata[6:0];
            two_wire_pkg::sstatus_off: if (hwdata[1]) r_next.s_held = 1'b0;
            default: ;
         endcase
      end
      // ****************
      // master engine
      // ****************
      // half period tick counting; held at zero while scl held low by the far side
      if (!(r_reg.ms inside {two_wire_pkg::m_idle, two_wire_pkg::m_held})) begin
         if (!r_reg.scl_low && !scl_q) begin
            r_next.tick = 8'h00;
         end else if (!tick_done) begin
            r_next.tick = r_reg.tick + 8'h01;
         end else begin
            r_next.tick = 8'h00;
         end
      end
      if (tick_done && !(!r_reg.scl_low && !scl_q)) begin
         unique case (r_reg.ms)
            two_wire_pkg::m_start_a: begin
               r_next.sda_low = 1'b1;
               r_next.ms = two_wire_pkg::m_start_b;
            end
            two_wire_pkg::m_start_b: begin
               r_next.scl_low = 1'b1;
               r_next.ms = two_wire_pkg::m_held;
            end
            two_wire_pkg::m_bit_low: begin
               // data set while scl low: release the clock
               r_next.scl_low = 1'b0;
               r_next.ms = two_wire_pkg::m_bit_high;
            end
            two_wire_pkg::m_bit_high: begin
               // sample and check arbitration at the end of the high phase
               if (!r_reg.is_read && !r_reg.sda_low && !sda_in && !r_reg.lost_now) begin
                  r_next.lost_now = 1'b1;
                  r_next.arb_lost = 1'b1;
               end
               r_next.shreg = {r_reg.shreg[6:0], sda_in};
               r_next.bitn = r_reg.bitn - 3'h1;
               r_next.scl_low = 1'b1;
               // next bit goes out with the clock low; only ones after a loss
               r_next.sda_low = !r_reg.is_read && !r_reg.shreg[6] && !r_next.lost_now;
               if (r_reg.bitn != 3'h0) begin
                  r_next.ms = two_wire_pkg::m_bit_low;
               end else if (r_reg.is_read) begin
                  // received byte complete: hold the clock
                  r_next.ms = two_wire_pkg::m_held;
                  r_next.rd_flag = !r_reg.bus_err;
                  r_next.wr_flag = r_reg.bus_err;
               end else begin
                  // release data for the slave's acknowledge
                  r_next.sda_low = 1'b0;
                  r_next.ms = two_wire_pkg::m_ack_low;
               end
            end
            two_wire_pkg::m_ack_low: begin
               r_next.scl_low = 1'b0;
               r_next.ms = two_wire_pkg::m_ack_high;
            end
            two_wire_pkg::m_ack_high: begin
               r_next.scl_low = 1'b1;
               r_next.sda_low = 1'b0;
               if (r_reg.is_read) begin
                  // ack or nack sent; a nack seen low means the bus was lost
                  if (r_reg.ack_act && !sda_in) begin
                     r_next.arb_lost = 1'b1;
                     r_next.wr_flag = 1'b1;
                     r_next.ms = two_wire_pkg::m_held;
                  end else begin
                     r_next.ms = two_wire_pkg::m_bit_low;
                  end
               end else begin
                  r_next.rx_ack = sda_in;
                  r_next.wr_flag = 1'b1;
                  r_next.rd_flag = 1'b0;
                  r_next.lost_now = 1'b0;
                  r_next.ms = two_wire_pkg::m_held;
                  if (r_reg.lost_now) begin
                     // lost: release the bus and wait for stop
                     r_next.scl_low = 1'b0;
                     r_next.ms = two_wire_pkg::m_idle;
                  end
               end
            end
            two_wire_pkg::m_stop_a: begin
               r_next.scl_low = 1'b0;
               r_next.ms = two_wire_pkg::m_stop_b;
            end
            two_wire_pkg::m_stop_b: begin
               r_next.sda_low = 1'b0;
               r_next.ms = two_wire_pkg::m_stop_c;
            end
            two_wire_pkg::m_stop_c: r_next.ms = two_wire_pkg::m_idle;
            default: ;
         endcase
      end
      // unexpected start or stop mid byte is a bus error
      if ((start_seen || stop_seen) && (r_reg.ms inside {two_wire_pkg::m_bit_low,
         two_wire_pkg::m_bit_high}) && !r_reg.lost_now) begin
         r_next.bus_err = 1'b1;
      end
      if (!r_reg.m_en) begin
         r_next.ms = two_wire_pkg::m_idle;
         r_next.scl_low = 1'b0;
         r_next.sda_low = 1'b0;
      end
      // ****************
      // slave engine, runs without system wake
      // ****************
      if (start_seen) begin
         r_next.s_active = r_reg.s_en;
         r_next.s_cnt = 4'h0;
         r_next.s_amatch = 1'b0;
      end else if (stop_seen) begin
         r_next.s_active = 1'b0;
         r_next.s_hold_req = 1'b0;
      end else if (r_reg.s_active && scl_q && !r_reg.s_hold_req) begin
         // sampled on the scl rising edge in the state register block via scl_prev
      end
      if (r_reg.s_active && r_reg.s_cnt == 4'h8 && !r_reg.s_amatch && !r_reg.s_held) begin
         if (addr_hit) begin
            r_next.s_amatch = 1'b1;
            r_next.s_held = 1'b1;
            r_next.wake = 1'b1;
         end else begin
            r_next.s_active = 1'b0;
         end
      end
      if (r_reg.s_active && r_reg.sda_low && !r_reg.scl_low && !sda_in == 1'b0) begin
         r_next.s_coll = 1'b1;
      end
      if (!r_reg.s_en) begin
         r_next.s_active = 1'b0;
      end
   end
   // slave bit capture on scl rising edge, counted separately
   logic scl_prev;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_prev <= 1'b1;
      end else begin
         scl_prev <= scl_in;
      end
   end
   // ****************
   // state registers
   // ****************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
         r_reg.ms <= two_wire_pkg::m_idle;
         r_reg.baud <= two_wire_pkg::baud_reset;
      end else begin
         r_reg <= r_next;
         if (r_reg.s_active && !scl_prev && scl_in && r_reg.s_cnt != 4'h8) begin
            r_reg.s_shreg <= {r_reg.s_shreg[6:0], sda_in};
            r_reg.s_cnt <= r_reg.s_cnt + 4'h1;
         end
      end
   end
   // ****************
   // outputs
   // ****************
   logic slave_scl_hold;
   assign slave_scl_hold = r_reg.s_held && !scl_prev;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         wake_req <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
      end else begin
         scl_oe <= r_next.scl_low || slave_scl_hold;
         sda_oe <= r_next.sda_low;
         wake_req <= r_next.wake;
         hreadyout <= 1'b1;
         hrdata <= r_next.rdata;
      end
   end
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign hresp = 1'b0;
endmodule
`default_nettype wire

//--- two_wire_pkg.sv
`default_nettype none
package two_wire_pkg;
   // ****************
   // register offsets
   // ****************
   localparam logic [7:0] mctrl_off = 8'h00;
   localparam logic [7:0] master_status_reg_off = 8'h04;
   localparam logic [7:0] mbaud_off = 8'h08;
   localparam logic [7:0] mcmd_off = 8'h0c;
   localparam logic [7:0] mdata_off = 8'h10;
   localparam logic [7:0] sctrl_off = 8'h14;
   localparam logic [7:0] saddr_off = 8'h18;
   localparam logic [7:0] smask_off = 8'h1c;
   localparam logic [7:0] sstatus_off = 8'h20;
   localparam logic [7:0] sdata_off = 8'h24;
   // ****************
   // field positions
   // ****************
   localparam int ms_read_bit = 7;
   localparam int ms_write_bit = 6;
   localparam int ms_held_bit = 5;
   localparam int ms_rxack_bit = 4;
   localparam int ms_arb_bit = 3;
   localparam int ms_err_bit = 2;
   localparam int ms_ack_act_bit = 0;
   // ****************
   // reset values and timing
   // ****************
   localparam logic [7:0] baud_reset = 8'h00;
   localparam int clk_hz = 40_000_000;
   localparam int bus_hz_std = 100_000;
   localparam int bus_hz_fast = 400_000;
   localparam int bus_hz_plus = 1_000_000;
   // half bit periods, default baud values for each rate
   localparam logic [7:0] baud_std = 8'(clk_hz / (2 * bus_hz_std) - 1);
   localparam logic [7:0] baud_fast = 8'(clk_hz / (2 * bus_hz_fast) - 1);
   localparam logic [7:0] baud_plus = 8'(clk_hz / (2 * bus_hz_plus) - 1);
   // master commands in command register
   localparam logic [1:0] cmd_none = 2'h0;
   localparam logic [1:0] cmd_start = 2'h1;
   localparam logic [1:0] cmd_stop = 2'h2;
   typedef enum logic [3:0] {
      m_idle, m_start_a, m_start_b, m_held, m_bit_low, m_bit_high, m_stop_a, m_stop_b, m_stop_c,
      m_ack_low, m_ack_high
   } mstate_t;
endpackage
`default_nettype wire

//--- bus_watch.sv
`default_nettype none
// ****************
// bus condition detector
// ****************
module bus_watch (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // line levels
   input wire logic scl,
   input wire logic sda,
   // detected events
   output logic start_seen,
   output logic stop_seen,
   output logic bus_busy
);
   typedef struct packed {
      logic scl_d;
      logic sda_d;
      logic busy;
   } watch_t;
   watch_t r_reg, r_next;
   // start: sda falls while scl high; stop: sda rises while scl high
   always_comb begin
      r_next = r_reg;
      r_next.scl_d = scl;
      r_next.sda_d = sda;
      if (start_seen) begin
         r_next.busy = 1'b1;
      end else if (stop_seen) begin
         r_next.busy = 1'b0;
      end
   end
   assign start_seen = r_reg.scl_d && scl && r_reg.sda_d && !sda;
   assign stop_seen = r_reg.scl_d && scl && !r_reg.sda_d && sda;
   assign bus_busy = r_reg.busy;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '{scl_d: 1'b1, sda_d: 1'b1, busy: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end
endmodule
`default_nettype wire

//--- two_wire_unit_sva.sv
`default_nettype none
// ****
// port checker for the two wire unit
// ****
module two_wire_unit_sva (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // line side
   input wire logic scl_out,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic scl_in,
   input wire logic wake_req
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_take;  // read address phase taken
   logic stat_dp;  // status read in data phase
   logic hole_dp;  // unmapped read in data phase
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   // data phase markers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_dp <= 1'b0;
         hole_dp <= 1'b0;
      end else begin
         stat_dp <= rd_take && (haddr[7:0] == two_wire_pkg::master_status_reg_off);
         hole_dp <= rd_take && (haddr[7:0] > two_wire_pkg::sdata_off);
      end
   end
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("error response on the bus");
   chk_zero_wait: assert property (hreadyout == 1'b1)
      else $error("wait state inserted");
   chk_pull_only: assert property (!scl_out && !sda_out)
      else $error("line driven high");
   chk_wake_single: assert property (wake_req |=> !wake_req)
      else $error("wake request longer than one cycle");
   chk_start_idle: assert property ($rose(sda_oe) && scl_in |-> $past(sda_in))
      else $error("start issued on a busy data line");
   chk_flags_apart: assert property (stat_dp |-> !(hrdata[7] && hrdata[6]))
      else $error("read and write flags both set");
   chk_hole_zero: assert property (hole_dp |-> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data changed without a read");
endmodule
bind two_wire_unit two_wire_unit_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .scl_out(scl_out), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in), .wake_req(wake_req));
`default_nettype wire

//--- far_slave.sv
`default_nettype none
// ****
// far side slave: acks its address, stretches before ack
// ****
module far_slave #(parameter logic [6:0] own_addr = 7'h2a) (
   // stretch timing clock
   input wire logic hclk,
   // line levels
   input wire logic scl,
   input wire logic sda,
   // stretch length in clocks
   input wire logic [7:0] stretch_len,
   // pulls, high means line low
   output logic scl_pull,
   output logic sda_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   int bitc = 0;  // bits seen, -1 after start
   logic [7:0] sh = 8'h00;  // sampled byte
   logic first = 1'b0;  // address byte pending
   logic sel = 1'b0;  // addressed
   initial scl_pull = 1'b0;
   initial sda_pull = 1'b0;
   // start watch
   always @(negedge sda) begin
      if (scl) begin
         bitc = -1;
         first = 1'b1;
      end
   end
   // stop watch
   always @(posedge sda) begin
      if (scl) begin
         sel = 1'b0;
      end
   end
   // sample on rising clock
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
   end
   // byte end: hold clock, then ack if addressed; never a start or stop of its own
   always @(negedge scl) begin
      bitc = bitc + 1;
      if (bitc == 8) begin
         if (first) begin
            sel = (sh[7:1] == own_addr);
         end
         scl_pull = 1'b1;
         repeat (stretch_len) @(posedge hclk);
         sda_pull = sel;
         @(posedge hclk);
         scl_pull = 1'b0;
      end else if (bitc == 9) begin
         bitc = 0;
         first = 1'b0;
         sda_pull = 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- two_wire_master_slave_port_bench.sv
`default_nettype none
module two_wire_master_slave_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // signals
   // ****
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tb_sda = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, q_val[$], q_msk[$];
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, scl_out, scl_oe, sda_out, sda_oe, wake_req, m_scl, m_sda;
   logic mon_go = 1'b0, dp = 1'b0, watch = 1'b0;
   logic [7:0] stretch = 8'h00, dat, bauds [3];
   logic [8:0] cap = '0;  // last nine bits on the line
   int err_total = 0, comparisons = 0, seed = 32'h778f_00b8, cyc = 0, t0, oe_hits = 0;
   wire logic scl = !(scl_oe || m_scl);  // wired and with pull-up
   wire logic sda = !(sda_oe || m_sda || tb_sda);
   always #12.5 hclk = !hclk;
   two_wire_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .wake_req(wake_req));
   far_slave u_far (.hclk(hclk), .scl(scl), .sda(sda), .stretch_len(stretch),
      .scl_pull(m_scl), .sda_pull(m_sda));
   // ****
   // tasks
   // ****
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // one ahb single transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // read with a noted expectation
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      q_val.push_back(v);
      q_msk.push_back(m);
      mon_go = 1'b1;
      bus(1'b0, a, '0);
      mon_go = 1'b0;
   endtask
   // poll status until a bit is set
   task automatic wait_bit(input int b);
      rd = '0;
      for (int n = 0; n < 1000 && rd[b] !== 1'b1; n++) bus(1'b0, two_wire_pkg::master_status_reg_off, '0);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED line value expected %h seen %h", exp, got);
      end
   endtask
   // ****
   // watchers
   // ****
   always @(posedge scl) cap <= {cap[7:0], sda};
   // read result monitor, oldest note first
   always @(posedge hclk) begin
      cyc++;
      if (watch && sda_oe) oe_hits++;
      if (dp) begin
         comparisons++;
         if ((hrdata & q_msk[0]) !== q_val[0]) begin
            err_total++;
            $display("CHECK FAILED hrdata expected %h seen %h", q_val[0], hrdata & q_msk[0]);
         end
         void'(q_val.pop_front());
         void'(q_msk.pop_front());
      end
      dp <= hsel && htrans[1] && !hwrite && hreadyout && mon_go;
      if (cyc == 40000) begin
         err_total++;
         $display("CHECK FAILED run time expected finish seen hang");
         complete_run();
      end
   end
   // ****
   // main sequence
   // ****
   initial begin
      bauds = '{two_wire_pkg::baud_std, two_wire_pkg::baud_fast, two_wire_pkg::baud_plus};
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      chk_rd(two_wire_pkg::mbaud_off, {24'h00_0000, two_wire_pkg::baud_reset}, 32'h0000_00ff);
      chk_rd(8'h40, 32'h0000_0000, 32'hffff_ffff);
      bus(1'b1, two_wire_pkg::mcmd_off, {30'h0, two_wire_pkg::cmd_start});
      repeat (100) @(posedge hclk);
      chk_rd(two_wire_pkg::master_status_reg_off, 32'h0000_0000, 32'h0000_00e0);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, two_wire_pkg::mbaud_off, {24'h00_0000, bauds[i]});
         chk_rd(two_wire_pkg::mbaud_off, {24'h00_0000, bauds[i]}, 32'h0000_00ff);
      end
      $display("test registers done");
      // address byte with a long stretch before the ack
      bus(1'b1, two_wire_pkg::mctrl_off, 32'h0000_0001);
      stretch = 8'd250;
      bus(1'b1, two_wire_pkg::mcmd_off, {30'h0, two_wire_pkg::cmd_start});
      wait_bit(two_wire_pkg::ms_held_bit);
      t0 = cyc;
      bus(1'b1, two_wire_pkg::mdata_off, 32'h0000_0054);
      bus(1'b1, two_wire_pkg::mdata_off, 32'h0000_00ff);
      wait_bit(two_wire_pkg::ms_write_bit);
      check(32'(cyc - t0 >= 560), 32'h0000_0001);
      check({23'h0, cap}, {23'h0, 8'h54, 1'b0});
      chk_rd(two_wire_pkg::master_status_reg_off, 32'h0000_0060, 32'h0000_00fc);
      $display("test address write done");
      // random data byte, no stretch, flags cleared by the write
      stretch = 8'd0;
      dat = 8'($random(seed));
      t0 = cyc;
      bus(1'b1, two_wire_pkg::mdata_off, {24'h00_0000, dat});
      chk_rd(two_wire_pkg::master_status_reg_off, 32'h0000_0000, 32'h0000_00cc);
      wait_bit(two_wire_pkg::ms_write_bit);
      check(32'(cyc - t0 >= 330 && cyc - t0 <= 480), 32'h0000_0001);
      check({23'h0, cap}, {23'h0, dat, 1'b0});
      $display("test data write done");
      // competing master pulls the first bit low
      bus(1'b1, two_wire_pkg::mcmd_off, {30'h0, two_wire_pkg::cmd_stop});
      repeat (200) @(posedge hclk);
      bus(1'b1, two_wire_pkg::mcmd_off, {30'h0, two_wire_pkg::cmd_start});
      wait_bit(two_wire_pkg::ms_held_bit);
      bus(1'b1, two_wire_pkg::mdata_off, 32'h0000_00ff);
      tb_sda <= 1'b1;
      @(negedge scl);
      @(posedge hclk);
      tb_sda <= 1'b0;
      watch <= 1'b1;
      wait_bit(two_wire_pkg::ms_write_bit);
      chk_rd(two_wire_pkg::master_status_reg_off, 32'h0000_0048, 32'h0000_00c8);
      bus(1'b1, two_wire_pkg::mcmd_off, {30'h0, two_wire_pkg::cmd_start});
      repeat (300) @(posedge hclk);
      check(oe_hits, 32'h0000_0000);
      $display("test arbitration done");
      complete_run();
   end
endmodule
`default_nettype wire
